// >>> core/sbg_top.sv
// Purpose : Secondary serial port baud generator with Avalon-MM registers
// Assumes : Single 100 MHz clock; serial engines consume the ticks outside
// Notes   : Every register access answers after one wait cycle
// Summary of operation
// - Eight-bit up counter and eight-bit reload register, both software accessible.
// - On overflow pulse once and reload the counter from the reload register.
// - Overflow pulse is the bit time base for modes 1 and 3.
// - With run clear, a reload write also writes the counter.
// - With run set, a reload write leaves the counter alone.
// - A counter write never changes the reload register.
// - Clock output toggles once per overflow, half the overflow rate.
// - Overflow always feeds the peripheral toggle output, engine busy or idle.
// - A software select routes the overflow to the first port.
// - Counter steps every 12 clocks, or every clock at full speed.
// - Modes 1 and 3 bit rate is overflow rate over 32, or 16 doubled.
// - Mode 2 bit rate is clock over 64 or 192, or over 32 or 96 when doubled.
// - Modes 0 and 4 shift rate is clock over 12, or 4 at full speed.
// - Mode 5 makes the block a plain auto-reload timer with overflow flag.
`timescale 1ns/1ps
module sbg_top (
    input  wire logic              I_SYS_CLK,          // System clock, 100 MHz
    input  wire logic              I_RST_N,            // Synchronous reset, active low
    input  wire logic [3:0]        I_AVS_ADDRESS,      // Byte address
    input  wire logic              I_AVS_READ,         // Read request
    input  wire logic              I_AVS_WRITE,        // Write request
    input  wire logic [31:0]       I_AVS_WRITEDATA,    // Write data
    input  wire logic [3:0]        I_AVS_BYTEENABLE,   // Byte lanes
    output logic [31:0]            O_AVS_READDATA,     // Read data, registered
    output logic                   O_AVS_WAITREQUEST,  // Stall until answer
    output sbg_pkg::sbg_tick_t     O_TICKS             // Time base outputs, registered
);
    import sbg_pkg::*;

    // Bus handshake state
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        wr_fire;
    logic        wr_lane0;

    // Register state
    sbg_ctrl_t   ctrl_reg;
    sbg_ctrl_t   ctrl_next;
    logic [7:0]  baud_reload_value_reg;
    logic [7:0]  baud_reload_value_next;
    logic [7:0]  baud_up_counter_reg;
    logic [7:0]  baud_up_counter_next;
    logic        tmr_flag_reg;
    logic        tmr_flag_next;

    // Time base state
    logic        pre_tick;
    logic        step;
    logic        ovf;
    logic        fix_tick;
    logic [7:0]  fix_div;
    logic        fix_en;
    logic [4:0]  ovf_sub_reg;
    logic [4:0]  ovf_sub_next;
    sbg_tick_t   ticks_reg;
    sbg_tick_t   ticks_next;

    // Modes in which the serial engine is clocked by overflows
    function automatic logic uses_brg(input logic [2:0] m);
        return (m == SBG_MODE_UART8) || (m == SBG_MODE_BRG9);
    endfunction

    // Modes in which a fixed division of the clock shifts bits
    function automatic logic uses_shift(input logic [2:0] m);
        return (m == SBG_MODE_SHIFT) || (m == SBG_MODE_SPI);
    endfunction

    // Request answered one cycle after it appears
    assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !ack_reg;
    assign wr_fire           = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    assign wr_lane0          = wr_fire && I_AVS_BYTEENABLE[0];
    assign O_AVS_READDATA    = rdata_reg;
    assign O_TICKS           = ticks_reg;

    // Handshake and read capture; read data stand at the accepting edge
    always_comb begin
        ack_next   = (I_AVS_READ || I_AVS_WRITE) && !ack_reg;
        rdata_next = rdata_reg;
        if (I_AVS_READ && !ack_reg) begin
            unique case (I_AVS_ADDRESS)
                SBG_OFF_CTRL:    rdata_next = {24'h000000, ctrl_reg};
                SBG_OFF_RELOAD:  rdata_next = {24'h000000, baud_reload_value_reg};
                SBG_OFF_COUNTER: rdata_next = {24'h000000, baud_up_counter_reg};
                SBG_OFF_STATUS: begin
                    rdata_next = 32'h00000000;
                    rdata_next[SBG_ST_CLKOUT_POS] = ticks_reg.port1_clock_out;
                    rdata_next[SBG_ST_TMRFLG_POS] = tmr_flag_reg;
                    rdata_next[SBG_ST_RUN_POS]    = ctrl_reg.baud_counter_run;
                end
                // Unmapped offsets read as zero
                default:         rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // Counter prescaler, only runs while the run bit is set
    sbg_div u_pre (
        .i_clk     (I_SYS_CLK),
        .i_rst_n   (I_RST_N),
        .i_en      (ctrl_reg.baud_counter_run),
        .i_divisor (ctrl_reg.prescale_full_speed ? SBG_PRE_FAST : SBG_PRE_SLOW),
        .o_tick    (pre_tick)
    );

    assign step = pre_tick && ctrl_reg.baud_counter_run;
    assign ovf  = step && (baud_up_counter_reg == 8'hFF);

    // Fixed clock divider for shift and mode 2 timing
    always_comb begin
        fix_en  = 1'b1;
        fix_div = SBG_SHIFT_SLOW;
        if (uses_shift(ctrl_reg.mode)) begin
            fix_div = ctrl_reg.prescale_full_speed ? SBG_SHIFT_FAST : SBG_SHIFT_SLOW;
        end else if (ctrl_reg.mode == SBG_MODE_UART9) begin
            fix_div = ctrl_reg.mode2_slow_select ? SBG_M2_DIV_SLOW : SBG_M2_DIV_FAST;
            if (ctrl_reg.baud_double) begin
                fix_div = {1'b0, fix_div[7:1]};
            end
        end else begin
            // Idle when overflows time the engine, saves toggling
            fix_en = 1'b0;
        end
    end

    sbg_div u_fix (
        .i_clk     (I_SYS_CLK),
        .i_rst_n   (I_RST_N),
        .i_en      (fix_en),
        .i_divisor (fix_div),
        .o_tick    (fix_tick)
    );

    // Control, reload, counter and timer flag
    always_comb begin
        ctrl_next              = ctrl_reg;
        baud_reload_value_next = baud_reload_value_reg;
        baud_up_counter_next   = baud_up_counter_reg;
        tmr_flag_next          = tmr_flag_reg;
        if (ovf) begin
            baud_up_counter_next = baud_reload_value_reg;
        end else if (step) begin
            baud_up_counter_next = baud_up_counter_reg + 8'h01;
        end
        if (wr_lane0) begin
            unique case (I_AVS_ADDRESS)
                SBG_OFF_CTRL: ctrl_next = sbg_ctrl_t'(I_AVS_WRITEDATA[7:0]);
                SBG_OFF_RELOAD: begin
                    baud_reload_value_next = I_AVS_WRITEDATA[7:0];
                    if (!ctrl_reg.baud_counter_run) begin
                        baud_up_counter_next = I_AVS_WRITEDATA[7:0];
                    end
                end
                SBG_OFF_COUNTER: baud_up_counter_next = I_AVS_WRITEDATA[7:0];
                SBG_OFF_STATUS: begin
                    if (I_AVS_WRITEDATA[SBG_ST_TMRFLG_POS]) begin
                        tmr_flag_next = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Set beats a clear arriving in the same cycle
        if (ovf && ctrl_reg.mode == SBG_MODE_TIMER) begin
            tmr_flag_next = 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ctrl_reg              <= sbg_ctrl_t'(SBG_CTRL_RST);
            baud_reload_value_reg <= SBG_RELOAD_RST;
            baud_up_counter_reg   <= SBG_COUNTER_RST;
            tmr_flag_reg          <= 1'b0;
        end else begin
            ctrl_reg              <= ctrl_next;
            baud_reload_value_reg <= baud_reload_value_next;
            baud_up_counter_reg   <= baud_up_counter_next;
            tmr_flag_reg          <= tmr_flag_next;
        end
    end

    // Output time bases; all registered so consumers see clean pulses
    always_comb begin
        ovf_sub_next = ovf_sub_reg;
        ticks_next   = ticks_reg;
        ticks_next.baud_overflow_pulse = ovf;
        ticks_next.periph_toggle       = ovf;
        ticks_next.port0_time_base     = ovf && ctrl_reg.port0_select;
        ticks_next.port1_bit_tick      = 1'b0;
        if (ovf) begin
            ticks_next.port1_clock_out = !ticks_reg.port1_clock_out;
        end
        if (uses_brg(ctrl_reg.mode)) begin
            if (ovf) begin
                ovf_sub_next = ovf_sub_reg + 5'h01;
                if (ctrl_reg.baud_double) begin
                    ticks_next.port1_bit_tick =
                        (ovf_sub_reg[3:0] == SBG_OVF_PER_BIT_DBL[3:0]);
                end else begin
                    ticks_next.port1_bit_tick = (ovf_sub_reg == SBG_OVF_PER_BIT);
                end
            end
        end else begin
            // Timer mode has no serial engine to feed
            ovf_sub_next = 5'h00;
            ticks_next.port1_bit_tick = fix_tick && (ctrl_reg.mode != SBG_MODE_TIMER);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ovf_sub_reg <= 5'h00;
            ticks_reg   <= '0;
        end else begin
            ovf_sub_reg <= ovf_sub_next;
            ticks_reg   <= ticks_next;
        end
    end

    // Checks on the counting behaviour
    sequence s_ovf_seen;
        ovf && !wr_fire;
    endsequence

    sequence s_toggle_follows;
        ##1 (ticks_reg.port1_clock_out != $past(ticks_reg.port1_clock_out));
    endsequence

    property p_ovf_reload;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        s_ovf_seen |=> (baud_up_counter_reg == $past(baud_reload_value_reg))
                       && ticks_reg.baud_overflow_pulse;
    endproperty
    a_ovf_reload: assert property (p_ovf_reload)
        else $error("counter not reloaded on overflow");

    property p_reload_writes_cnt;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (wr_lane0 && I_AVS_ADDRESS == SBG_OFF_RELOAD && !ctrl_reg.baud_counter_run)
        |=> (baud_up_counter_reg == $past(I_AVS_WRITEDATA[7:0]));
    endproperty
    a_reload_writes_cnt: assert property (p_reload_writes_cnt)
        else $error("stopped reload write missed counter");

    property p_reload_keeps_cnt;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (wr_lane0 && I_AVS_ADDRESS == SBG_OFF_RELOAD && ctrl_reg.baud_counter_run && !step)
        |=> $stable(baud_up_counter_reg);
    endproperty
    a_reload_keeps_cnt: assert property (p_reload_keeps_cnt)
        else $error("running reload write changed counter");

    property p_cnt_write_keeps_reload;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (wr_fire && I_AVS_ADDRESS == SBG_OFF_COUNTER) |=> $stable(baud_reload_value_reg);
    endproperty
    a_cnt_write_keeps_reload: assert property (p_cnt_write_keeps_reload)
        else $error("counter write changed reload");

    property p_clkout_toggle;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        ovf |-> s_toggle_follows;
    endproperty
    a_clkout_toggle: assert property (p_clkout_toggle)
        else $error("clock output did not toggle on overflow");

    property p_port0_route;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        ticks_reg.port0_time_base |-> $past(ovf) && $past(ctrl_reg.port0_select)
                                      && ticks_reg.periph_toggle;
    endproperty
    a_port0_route: assert property (p_port0_route)
        else $error("first port time base without overflow");

    property p_slow_prescale;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (step && !ctrl_reg.prescale_full_speed && !ctrl_next.prescale_full_speed)
        |=> !step [*8];
    endproperty
    a_slow_prescale: assert property (p_slow_prescale)
        else $error("slow prescale stepped too soon");

    property p_stopped_holds;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (!ctrl_reg.baud_counter_run && !wr_fire) |=> $stable(baud_up_counter_reg) && !$past(ovf);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds)
        else $error("counter moved while stopped");

    property p_timer_flag;
        @(posedge I_SYS_CLK) disable iff (!I_RST_N)
        (ovf && ctrl_reg.mode == SBG_MODE_TIMER) |=> tmr_flag_reg;
    endproperty
    a_timer_flag: assert property (p_timer_flag)
        else $error("timer flag not set on overflow");

endmodule

// >>> core/sbg_pkg.sv
// Purpose : Shared constants and types for the secondary port baud generator
// Assumes : 32-bit Avalon-MM register window, byte addresses, one clock
// Notes   : All data registers are 8 bits wide in the low byte lane
package sbg_pkg;

    // Register byte offsets
    localparam logic [3:0] SBG_OFF_CTRL    = 4'h0;
    localparam logic [3:0] SBG_OFF_RELOAD  = 4'h4;
    localparam logic [3:0] SBG_OFF_COUNTER = 4'h8;
    localparam logic [3:0] SBG_OFF_STATUS  = 4'hC;

    // Status field positions
    localparam int SBG_ST_CLKOUT_POS = 0;
    localparam int SBG_ST_TMRFLG_POS = 1;
    localparam int SBG_ST_RUN_POS    = 2;

    // Reset values
    localparam logic [7:0] SBG_CTRL_RST    = 8'h00;
    localparam logic [7:0] SBG_RELOAD_RST  = 8'h00;
    localparam logic [7:0] SBG_COUNTER_RST = 8'h00;

    // Serial mode codes held in the control register
    localparam logic [2:0] SBG_MODE_SHIFT = 3'h0;
    localparam logic [2:0] SBG_MODE_UART8 = 3'h1;
    localparam logic [2:0] SBG_MODE_UART9 = 3'h2;
    localparam logic [2:0] SBG_MODE_BRG9  = 3'h3;
    localparam logic [2:0] SBG_MODE_SPI   = 3'h4;
    localparam logic [2:0] SBG_MODE_TIMER = 3'h5;

    // Division counts in system clocks or overflows
    localparam logic [7:0] SBG_PRE_SLOW    = 8'h0C;  // Counter step every 12 clocks
    localparam logic [7:0] SBG_PRE_FAST    = 8'h01;
    localparam logic [7:0] SBG_SHIFT_SLOW  = 8'h0C;
    localparam logic [7:0] SBG_SHIFT_FAST  = 8'h04;
    localparam logic [7:0] SBG_M2_DIV_FAST = 8'h40;  // 64
    localparam logic [7:0] SBG_M2_DIV_SLOW = 8'hC0;  // 192
    localparam logic [4:0] SBG_OVF_PER_BIT = 5'h1F;  // Last of 32 overflows
    localparam logic [4:0] SBG_OVF_PER_BIT_DBL = 5'h0F;  // Last of 16

    // Control register layout, bit 0 is the run bit
    typedef struct packed {
        logic [2:0] mode;
        logic       port0_select;
        logic       mode2_slow_select;
        logic       baud_double;
        logic       prescale_full_speed;
        logic       baud_counter_run;
    } sbg_ctrl_t;

    // Time base outputs travelling together
    typedef struct packed {
        logic baud_overflow_pulse;
        logic periph_toggle;
        logic port0_time_base;
        logic port1_clock_out;
        logic port1_bit_tick;
    } sbg_tick_t;

endpackage

// >>> core/sbg_div.sv
// Purpose : Programmable enable divider producing a one-cycle tick
// Assumes : Divisor changes only between uses; divisor of 1 ticks every clock
// Notes   : Count restarts from zero whenever the enable drops
`timescale 1ns/1ps
module sbg_div (
    input  wire logic       i_clk,      // System clock
    input  wire logic       i_rst_n,    // Synchronous reset, active low
    input  wire logic       i_en,       // Divider running
    input  wire logic [7:0] i_divisor,  // Clocks per tick
    output logic            o_tick      // One-cycle tick
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       last;

    // Last count of the period
    assign last   = (cnt_reg >= (i_divisor - 8'h01));
    assign o_tick = i_en && last;

    // Next count
    always_comb begin
        cnt_next = cnt_reg;
        if (!i_en || last) begin
            cnt_next = 8'h00;
        end else begin
            cnt_next = cnt_reg + 8'h01;
        end
    end

    // Count register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// >>> verif/sbg_sink.sv
// Purpose : Far-side model: serial engine and peripheral clock inputs
// Assumes : Ticks are one-cycle pulses, clock out is a level
// Notes   : Gaps count clocks between the last two events of a kind
`timescale 1ns/1ps
module sbg_sink
    import sbg_pkg::*;
(
    input  wire logic               i_clk,      // System clock
    input  wire logic               i_rst_n,    // Synchronous reset, active low
    input  wire logic               i_clear,    // Clear counts and gaps
    input  wire sbg_pkg::sbg_tick_t i_ticks,    // Time base inputs
    output logic [15:0]             o_ovf_cnt,  // Overflow pulses seen
    output logic [15:0]             o_per_cnt,  // Peripheral toggles seen
    output logic [15:0]             o_p0_cnt,   // First port time base pulses
    output logic [15:0]             o_tog_cnt,  // Clock out flips seen
    output logic [15:0]             o_bit_cnt,  // Serial bit ticks seen
    output logic [15:0]             o_ovf_gap,  // Clocks between overflows
    output logic [15:0]             o_bit_gap   // Clocks between bit ticks
);
    logic [15:0] ovf_run_reg;
    logic [15:0] bit_run_reg;
    logic        clk_out_reg;

    // Engine and peripherals consume every pulse, busy or idle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            {o_ovf_cnt, o_per_cnt, o_p0_cnt, o_tog_cnt, o_bit_cnt} <= '0;
            {o_ovf_gap, o_bit_gap, ovf_run_reg, bit_run_reg} <= '0;
            clk_out_reg <= i_ticks.port1_clock_out;
        end else begin
            clk_out_reg <= i_ticks.port1_clock_out;
            ovf_run_reg <= i_ticks.baud_overflow_pulse ? 16'h0000 : ovf_run_reg + 16'h0001;
            bit_run_reg <= i_ticks.port1_bit_tick ? 16'h0000 : bit_run_reg + 16'h0001;
            if (i_ticks.baud_overflow_pulse) begin
                o_ovf_cnt <= o_ovf_cnt + 16'h0001;
                o_ovf_gap <= ovf_run_reg + 16'h0001;
            end
            if (i_ticks.port1_bit_tick) begin
                o_bit_cnt <= o_bit_cnt + 16'h0001;
                o_bit_gap <= bit_run_reg + 16'h0001;
            end
            if (i_ticks.periph_toggle) o_per_cnt <= o_per_cnt + 16'h0001;
            if (i_ticks.port0_time_base) o_p0_cnt <= o_p0_cnt + 16'h0001;
            if (i_ticks.port1_clock_out != clk_out_reg) o_tog_cnt <= o_tog_cnt + 16'h0001;
        end
    end
endmodule

// >>> verif/tb.sv
// Purpose : Self-checking bench for the secondary port baud generator
// Assumes : One wait cycle per bus access; ticks watched by the sink model
// Notes   : Reads queue their expectation, a watcher compares on answer
`timescale 1ns/1ps
module tb;
    import sbg_pkg::*;
    typedef struct packed {
        logic [2:0]  mode;
        logic        slow, dbl, fs;
        logic [7:0]  rl;
        logic [15:0] og, bg;
    } sbg_case_t;

    logic I_SYS_CLK, I_RST_N, I_AVS_READ, I_AVS_WRITE, clr;
    logic [3:0] I_AVS_ADDRESS, I_AVS_BYTEENABLE;
    logic [31:0] I_AVS_WRITEDATA, O_AVS_READDATA;
    logic O_AVS_WAITREQUEST;
    sbg_tick_t O_TICKS;
    logic [15:0] n_ovf, n_per, n_p0, n_tog, n_bit, g_ovf, g_bit, held;
    logic [63:0] exp_q[$];
    logic [63:0] ent;
    logic [7:0] rv, cv;
    sbg_case_t cases[11];
    int failures, check_count, cycles;
    integer seed;

    sbg_top u_dut (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_AVS_ADDRESS(I_AVS_ADDRESS),
        .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
        .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
        .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_TICKS(O_TICKS));
    sbg_sink u_sink (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_clear(clr), .i_ticks(O_TICKS),
        .o_ovf_cnt(n_ovf), .o_per_cnt(n_per), .o_p0_cnt(n_p0), .o_tog_cnt(n_tog),
        .o_bit_cnt(n_bit), .o_ovf_gap(g_ovf), .o_bit_gap(g_bit));

    // Free-running 100 MHz clock
    initial begin
        I_SYS_CLK = 1'b0;
        forever #5 I_SYS_CLK = ~I_SYS_CLK;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check_rd(input logic [31:0] e, input logic [31:0] m, input logic [31:0] s);
        check_count++;
        if ((s & m) !== (e & m)) begin
            failures++;
            $display("mismatch readdata expected %h seen %h", e & m, s & m);
        end
    endtask

    task automatic check_num(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", n, e, s);
        end
    endtask

    // One held request per access; a clock passes before the next one
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [7:0] e, input logic [7:0] m);
        if (!wr) exp_q.push_back({24'h000000, e, 24'hFFFFFF, m});
        I_AVS_ADDRESS <= a;
        I_AVS_WRITEDATA <= d;
        I_AVS_BYTEENABLE <= be;
        I_AVS_WRITE <= wr;
        I_AVS_READ <= !wr;
        do @(posedge I_SYS_CLK); while (O_AVS_WAITREQUEST !== 1'b0);
        I_AVS_WRITE <= 1'b0;
        I_AVS_READ <= 1'b0;
        @(posedge I_SYS_CLK);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'hA5A5A5, d}, 4'hF, 8'h00, 8'h00);
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        bus(1'b0, a, 32'h00000000, 4'hF, e, m);
    endtask

    function automatic logic [7:0] ctl(input sbg_case_t c, input logic sel, input logic run);
        sbg_ctrl_t r;
        r = '{c.mode, sel, c.slow, c.dbl, c.fs, run};
        return r;
    endfunction

    // Watcher: oldest note against each answered read
    always @(posedge I_SYS_CLK) begin
        if (I_AVS_READ === 1'b1 && O_AVS_WAITREQUEST === 1'b0) begin
            ent = exp_q.pop_front();
            check_rd(ent[63:32], ent[31:0], O_AVS_READDATA);
        end
    end

    // Hang guard
    always @(posedge I_SYS_CLK) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        seed = 32'hcab0;
        {I_AVS_READ, I_AVS_WRITE, clr, I_RST_N} = '0;
        I_AVS_ADDRESS = 4'h0;
        I_AVS_WRITEDATA = 32'h00000000;
        I_AVS_BYTEENABLE = 4'hF;
        // mode, slow, dbl, fs, reload, overflow gap, bit gap
        cases[0] = '{SBG_MODE_UART8, 1'b0, 1'b0, 1'b1, 8'hFE, 16'd2, 16'd64};
        cases[1] = '{SBG_MODE_BRG9, 1'b0, 1'b1, 1'b1, 8'hFE, 16'd2, 16'd32};
        cases[2] = '{SBG_MODE_UART8, 1'b0, 1'b1, 1'b0, 8'hFF, 16'd12, 16'd192};
        cases[3] = '{SBG_MODE_BRG9, 1'b0, 1'b0, 1'b1, 8'hFF, 16'd1, 16'd32};
        cases[4] = '{SBG_MODE_UART9, 1'b0, 1'b0, 1'b1, 8'hFE, 16'd2, 16'd64};
        cases[5] = '{SBG_MODE_UART9, 1'b1, 1'b0, 1'b1, 8'hFE, 16'd2, 16'd192};
        cases[6] = '{SBG_MODE_UART9, 1'b0, 1'b1, 1'b1, 8'hFE, 16'd2, 16'd32};
        cases[7] = '{SBG_MODE_UART9, 1'b1, 1'b1, 1'b1, 8'hFE, 16'd2, 16'd96};
        cases[8] = '{SBG_MODE_SHIFT, 1'b0, 1'b0, 1'b0, 8'hFF, 16'd12, 16'd12};
        cases[9] = '{SBG_MODE_SPI, 1'b0, 1'b0, 1'b1, 8'hF0, 16'd16, 16'd4};
        cases[10] = '{SBG_MODE_TIMER, 1'b0, 1'b0, 1'b1, 8'h80, 16'd128, 16'd0};
        repeat (6) @(posedge I_SYS_CLK);
        I_RST_N <= 1'b1;
        @(posedge I_SYS_CLK);
        // Reset values, unmapped address
        rd_reg(SBG_OFF_CTRL, SBG_CTRL_RST, 8'hFF);
        rd_reg(SBG_OFF_RELOAD, SBG_RELOAD_RST, 8'hFF);
        rd_reg(SBG_OFF_COUNTER, SBG_COUNTER_RST, 8'hFF);
        rd_reg(SBG_OFF_STATUS, 8'h00, 8'hFF);
        rd_reg(4'h2, 8'h00, 8'hFF);
        // Stopped: reload write loads counter, counter write spares reload
        repeat (4) begin
            rv = $random(seed);
            cv = $random(seed);
            wr_reg(SBG_OFF_RELOAD, rv);
            rd_reg(SBG_OFF_COUNTER, rv, 8'hFF);
            wr_reg(SBG_OFF_COUNTER, cv);
            rd_reg(SBG_OFF_RELOAD, rv, 8'hFF);
            repeat (40) @(posedge I_SYS_CLK);
            rd_reg(SBG_OFF_COUNTER, cv, 8'hFF);
        end
        bus(1'b1, SBG_OFF_COUNTER, 32'h000000AA, 4'hE, 8'h00, 8'h00);
        wr_reg(4'h1, 8'hFF);
        rd_reg(SBG_OFF_COUNTER, cv, 8'hFF);
        rd_reg(SBG_OFF_RELOAD, rv, 8'hFF);
        // Running: reload write must not touch the counter
        wr_reg(SBG_OFF_RELOAD, 8'h10);
        wr_reg(SBG_OFF_CTRL, 8'h21);
        wr_reg(SBG_OFF_RELOAD, 8'hF0);
        rd_reg(SBG_OFF_COUNTER, 8'h00, 8'hE0);
        // Rate table: overflow spacing, bit spacing, outputs per overflow
        for (int i = 0; i < 11; i++) begin
            // Stop in the case's own mode, so no stray shift tick follows the clear
            wr_reg(SBG_OFF_CTRL, ctl(cases[i], i[0], 1'b0));
            wr_reg(SBG_OFF_RELOAD, cases[i].rl);
            clr <= 1'b1;
            @(posedge I_SYS_CLK);
            clr <= 1'b0;
            wr_reg(SBG_OFF_CTRL, ctl(cases[i], i[0], 1'b1));
            repeat (900) @(posedge I_SYS_CLK);
            rd_reg(SBG_OFF_STATUS, (cases[i].mode == SBG_MODE_TIMER) ? 8'h06 : 8'h04, 8'h06);
            wr_reg(SBG_OFF_CTRL, ctl(cases[i], i[0], 1'b0));
            repeat (20) @(posedge I_SYS_CLK);
            check_num("overflow gap", cases[i].og, g_ovf);
            check_num("bit gap", cases[i].bg, g_bit);
            if (cases[i].bg == 16'd0) check_num("bit ticks", 16'd0, n_bit);
            check_num("peripheral toggles", n_ovf, n_per);
            check_num("clock out flips", n_ovf, n_tog);
            check_num("first port base", i[0] ? n_ovf : 16'd0, n_p0);
            held = n_ovf;
            repeat (300) @(posedge I_SYS_CLK);
            check_num("held overflows", held, n_ovf);
        end
        // Timer flag clears on a written one while stopped
        wr_reg(SBG_OFF_STATUS, 8'h02);
        rd_reg(SBG_OFF_STATUS, 8'h00, 8'h06);
        final_report();
    end
endmodule
